/* File: stsr_map.vh */
// Register indices, field positions and reset values for the arm and measure layer status sets
`ifndef STSR_MAP_VH
`define STSR_MAP_VH

// Register select codes on the command port
`define STSR_SEL_ARM_COND 4'h0
`define STSR_SEL_ARM_RISE 4'h1
`define STSR_SEL_ARM_FALL 4'h2
`define STSR_SEL_ARM_EVT 4'h3
`define STSR_SEL_ARM_MASK 4'h4
`define STSR_SEL_MEAS_COND 4'h5
`define STSR_SEL_MEAS_RISE 4'h6
`define STSR_SEL_MEAS_FALL 4'h7
`define STSR_SEL_MEAS_EVT 4'h8
`define STSR_SEL_MEAS_MASK 4'h9

// Bit positions
`define STSR_ARM1_BIT 1
`define STSR_ARM2_BIT 2
`define STSR_MEAS_BIT 1

// Positions that carry a defined event
`define STSR_ARM_VALID 16'h0006
`define STSR_MEAS_VALID 16'h0002

// Reset and preset values
`define STSR_RISE_RST 16'hffff
`define STSR_FALL_RST 16'h0000
`define STSR_MASK_RST 16'h0000
`define STSR_EVT_RST 16'h0000
`define STSR_COND_RST 16'h0000

`endif

/* File: stsr_event_latch.v */
// Transition filter and latched event register for one status set
`include "stsr_map.vh"
`default_nettype none

module stsr_event_latch #(
  parameter [15:0] VALID = 16'hffff
) (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Live condition and filters
  input wire [15:0] condIn,
  input wire [15:0] riseFilter,
  input wire [15:0] fallFilter,
  // Clear request
  input wire clearEvt,
  // Latched events
  output reg [15:0] eventOut
);

  reg [15:0] prevCond_r;
  wire [15:0] rising;
  wire [15:0] falling;
  wire [15:0] hits;

  assign rising = condIn & ~prevCond_r & riseFilter; // see RL5
  assign falling = ~condIn & prevCond_r & fallFilter; // see RL6
  assign hits = (rising | falling) & VALID; // see RL21

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prevCond_r <= `STSR_COND_RST;
      eventOut <= `STSR_EVT_RST;
    end else begin
      prevCond_r <= condIn;
      // A new edge in the clearing cycle survives the clear
      eventOut <= (clearEvt ? `STSR_EVT_RST : eventOut) | hits; // see RL10
    end
  end

endmodule // stsr_event_latch

`default_nettype wire

/* File: stsr_status_regs.v */
// Arm layer and measure layer status register sets with summary outputs
//
// How it works
// RL1 - Arm set uses only bits B1, B2
// RL2 - Arm condition B1 means first arm layer
// RL3 - Arm condition B2 means scan layer
// RL4 - Condition register is read-only, always live
// RL5 - Rise filter bit catches 0 to 1
// RL6 - Fall filter bit catches 1 to 0
// RL7 - Two writable 16-bit filters per set
// RL8 - Reading a filter changes nothing
// RL9 - Reset or preset: rise all ones, fall zero
// RL10 - Event bits stay set until cleared
// RL11 - Event read returns contents then clears
// RL12 - Arm events cleared by reset, clear-status, read
// RL13 - Arm summary is OR of event AND mask
// RL14 - Mask zero blocks, mask one passes
// RL15 - Mask reads harmless; cleared by reset/write zero
// RL16 - Measure condition B1 means measure layer
// RL17 - Measure filter acts on B1 only
// RL18 - Measure summary drives waiting-for-trigger bit
// RL19 - Measure events cleared by reset, clear-status, read
// RL20 - Host programs only mask bit B1
// RL21 - Undefined positions read zero in condition and event registers; filters and masks read back all 16 bits as written
`include "stsr_map.vh"
`default_nettype none

module stsr_status_regs (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Live instrument layer state
  input wire inArmLayer1,
  input wire inArmLayer2,
  input wire inMeasureLayer,
  // Decoded command port
  input wire cmdValid,
  input wire cmdWrite,
  input wire [3:0] cmdSel,
  input wire [15:0] cmdWdata,
  input wire clearStatus,
  input wire statusPreset,
  // Read answer
  output reg rdValid,
  output reg [15:0] rdData,
  // Summary bits
  output reg armSummary,
  output reg waitTrigSummary
);

  // Registered state and its next values
  reg [15:0] armCond_r;
  reg [15:0] armCond_nxt;
  reg [15:0] armRise_r;
  reg [15:0] armRise_nxt;
  reg [15:0] armFall_r;
  reg [15:0] armFall_nxt;
  reg [15:0] armMask_r;
  reg [15:0] armMask_nxt;
  reg [15:0] measCond_r;
  reg [15:0] measCond_nxt;
  reg [15:0] measRise_r;
  reg [15:0] measRise_nxt;
  reg [15:0] measFall_r;
  reg [15:0] measFall_nxt;
  reg [15:0] measMask_r;
  reg [15:0] measMask_nxt;

  // Next values of the output flops
  reg rdValid_nxt;
  reg [15:0] rdData_nxt;
  reg armSummary_nxt;
  reg waitTrigSummary_nxt;
  reg [15:0] rdMux;

  // Latched event words
  wire [15:0] armEvt;
  wire [15:0] measEvt;

  // Decoded command strobes
  wire rdStrobe;
  wire wrStrobe;
  wire armRiseWr;
  wire armFallWr;
  wire armMaskWr;
  wire measRiseWr;
  wire measFallWr;
  wire measMaskWr;
  wire armEvtRd;
  wire measEvtRd;
  wire armEvtClr;
  wire measEvtClr;

  // OR over all positions of event AND mask; undefined positions never count
  function summary;
    input [15:0] evt;
    input [15:0] mask;
    input [15:0] valid;
    begin
      summary = |(evt & mask & valid); // see RL14
    end
  endfunction

  function cmdHit;
    input [3:0] sel;
    input [3:0] code;
    input strobe;
    begin
      cmdHit = strobe && (sel == code);
    end
  endfunction

  // Preset wins over a filter write landing in the same cycle
  function [15:0] filterNext;
    input [15:0] cur;
    input preset;
    input [15:0] presetVal;
    input wr;
    input [15:0] wdata;
    begin
      if (preset) begin
        filterNext = presetVal;
      end else if (wr) begin
        filterNext = wdata;
      end else begin
        filterNext = cur;
      end
    end
  endfunction

  // A mask changes only on its own write; preset leaves it alone
  function [15:0] maskNext;
    input [15:0] cur;
    input wr;
    input [15:0] wdata;
    begin
      if (wr) begin
        maskNext = wdata;
      end else begin
        maskNext = cur;
      end
    end
  endfunction

  assign rdStrobe = cmdValid && !cmdWrite;
  assign wrStrobe = cmdValid && cmdWrite;
  assign armRiseWr = cmdHit(cmdSel, `STSR_SEL_ARM_RISE, wrStrobe); // see RL7
  assign armFallWr = cmdHit(cmdSel, `STSR_SEL_ARM_FALL, wrStrobe);
  assign armMaskWr = cmdHit(cmdSel, `STSR_SEL_ARM_MASK, wrStrobe);
  assign measRiseWr = cmdHit(cmdSel, `STSR_SEL_MEAS_RISE, wrStrobe);
  assign measFallWr = cmdHit(cmdSel, `STSR_SEL_MEAS_FALL, wrStrobe);
  assign measMaskWr = cmdHit(cmdSel, `STSR_SEL_MEAS_MASK, wrStrobe);
  // Condition and event selects have no write enable at all
  assign armEvtRd = cmdHit(cmdSel, `STSR_SEL_ARM_EVT, rdStrobe); // see RL11
  assign measEvtRd = cmdHit(cmdSel, `STSR_SEL_MEAS_EVT, rdStrobe);
  assign armEvtClr = clearStatus || armEvtRd; // see RL12
  assign measEvtClr = clearStatus || measEvtRd; // see RL19

  // Live layer state, sampled once so every path sees one copy
  always @* begin
    armCond_nxt = `STSR_COND_RST; // see RL1
    armCond_nxt[`STSR_ARM1_BIT] = inArmLayer1; // see RL2
    armCond_nxt[`STSR_ARM2_BIT] = inArmLayer2; // see RL3
  end

  always @* begin
    measCond_nxt = `STSR_COND_RST;
    measCond_nxt[`STSR_MEAS_BIT] = inMeasureLayer; // see RL16
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armCond_r <= `STSR_COND_RST;
    end else begin
      armCond_r <= armCond_nxt; // see RL4
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      measCond_r <= `STSR_COND_RST;
    end else begin
      measCond_r <= measCond_nxt;
    end
  end

  // Filters change on a write or a preset, nothing else
  always @* begin
    armRise_nxt = filterNext(armRise_r, statusPreset, `STSR_RISE_RST, armRiseWr, cmdWdata); // see RL9
    armFall_nxt = filterNext(armFall_r, statusPreset, `STSR_FALL_RST, armFallWr, cmdWdata);
  end

  always @* begin
    measRise_nxt = filterNext(measRise_r, statusPreset, `STSR_RISE_RST, measRiseWr, cmdWdata);
    measFall_nxt = filterNext(measFall_r, statusPreset, `STSR_FALL_RST, measFallWr, cmdWdata);
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armRise_r <= `STSR_RISE_RST; // see RL9
    end else begin
      armRise_r <= armRise_nxt; // see RL7
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armFall_r <= `STSR_FALL_RST;
    end else begin
      armFall_r <= armFall_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      measRise_r <= `STSR_RISE_RST;
    end else begin
      measRise_r <= measRise_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      measFall_r <= `STSR_FALL_RST;
    end else begin
      measFall_r <= measFall_nxt;
    end
  end

  always @* begin
    armMask_nxt = maskNext(armMask_r, armMaskWr, cmdWdata); // see RL15
  end

  // Every bit is stored, but only B1 ever reaches the summary
  always @* begin
    measMask_nxt = maskNext(measMask_r, measMaskWr, cmdWdata);
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armMask_r <= `STSR_MASK_RST; // see RL15
    end else begin
      armMask_r <= armMask_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      measMask_r <= `STSR_MASK_RST;
    end else begin
      measMask_r <= measMask_nxt;
    end
  end

  stsr_event_latch #(
    .VALID(`STSR_ARM_VALID)
  ) armLatch (
    .core_clk(core_clk),
    .nrst(nrst),
    .condIn(armCond_r),
    .riseFilter(armRise_r),
    .fallFilter(armFall_r),
    .clearEvt(armEvtClr),
    .eventOut(armEvt)
  );

  stsr_event_latch #(
    .VALID(`STSR_MEAS_VALID)
  ) measLatch (
    .core_clk(core_clk),
    .nrst(nrst),
    .condIn(measCond_r),
    .riseFilter(measRise_r),
    .fallFilter(measFall_r),
    .clearEvt(measEvtClr),
    .eventOut(measEvt)
  ); // see RL17

  // Read mux; filters and masks read back as written
  always @* begin
    case (cmdSel)
      `STSR_SEL_ARM_COND: rdMux = armCond_r; // see RL4
      `STSR_SEL_ARM_RISE: rdMux = armRise_r; // see RL8
      `STSR_SEL_ARM_FALL: rdMux = armFall_r;
      `STSR_SEL_ARM_EVT: rdMux = armEvt; // see RL11
      `STSR_SEL_ARM_MASK: rdMux = armMask_r;
      `STSR_SEL_MEAS_COND: rdMux = measCond_r;
      `STSR_SEL_MEAS_RISE: rdMux = measRise_r;
      `STSR_SEL_MEAS_FALL: rdMux = measFall_r;
      `STSR_SEL_MEAS_EVT: rdMux = measEvt;
      `STSR_SEL_MEAS_MASK: rdMux = measMask_r;
      default: rdMux = 16'h0000;
    endcase
  end

  // Output flops; rdData keeps the last answer between reads
  always @* begin
    rdValid_nxt = rdStrobe;
    rdData_nxt = rdData;
    if (rdStrobe) begin
      rdData_nxt = rdMux;
    end
  end

  // Summaries lag the event word by one flop
  always @* begin
    armSummary_nxt = summary(armEvt, armMask_r, `STSR_ARM_VALID); // see RL13
  end

  always @* begin
    waitTrigSummary_nxt = summary(measEvt, measMask_r, `STSR_MEAS_VALID); // see RL18
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdValid_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 16'h0000;
    end else begin
      rdData <= rdData_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armSummary <= 1'b0;
    end else begin
      armSummary <= armSummary_nxt;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waitTrigSummary <= 1'b0;
    end else begin
      waitTrigSummary <= waitTrigSummary_nxt;
    end
  end

endmodule // stsr_status_regs

`default_nettype wire

/* File: stsr_checker_properties.sv */
// Port checks for the status register sets
`default_nettype none
module stsr_checker (
  // Clock, reset and layers
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic inArmLayer1,
  input wire logic inArmLayer2,
  input wire logic inMeasureLayer,
  // Commands and answers
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [3:0] cmdSel,
  input wire logic clearStatus,
  input wire logic rdValid,
  input wire logic [15:0] rdData,
  input wire logic waitTrigSummary
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic rdReq = cmdValid && !cmdWrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property (rdReq |=> rdValid) else $error("no answer");
  a_no_stray: assert property (!rdReq |=> !rdValid) else $error("stray answer");
  a_arm_cond: assert property (rdReq && cmdSel == 4'h0 |=>
    rdData == {13'h0, $past(inArmLayer2, 2), $past(inArmLayer1, 2), 1'h0}) else $error("arm cond");
  a_meas_cond: assert property (rdReq && cmdSel == 4'h5 |=>
    rdData == {14'h0, $past(inMeasureLayer, 2), 1'h0}) else $error("meas cond");
  a_arm_bits: assert property (rdReq && cmdSel == 4'h3 |=> (rdData & 16'hfff9) == 16'h0) else $error("arm bits");
  a_meas_bits: assert property (rdReq && cmdSel == 4'h8 |=> (rdData & 16'hfffd) == 16'h0) else $error("meas bits");
  a_unmapped_zero: assert property (rdReq && cmdSel > 4'h9 |=> rdData == 16'h0) else $error("unmapped");
  a_meas_clear: assert property (clearStatus && $stable(inMeasureLayer) &&
    $past(inMeasureLayer) == $past(inMeasureLayer, 2) |-> ##2 !waitTrigSummary) else $error("trig clear");
endmodule // stsr_checker
bind stsr_status_regs stsr_checker i_chk (
  .core_clk(core_clk),
  .nrst(nrst),
  .inArmLayer1(inArmLayer1),
  .inArmLayer2(inArmLayer2),
  .inMeasureLayer(inMeasureLayer),
  .cmdValid(cmdValid),
  .cmdWrite(cmdWrite),
  .cmdSel(cmdSel),
  .clearStatus(clearStatus),
  .rdValid(rdValid),
  .rdData(rdData),
  .waitTrigSummary(waitTrigSummary)
);
`default_nettype wire

/* File: stsr_host.sv */
// Host model issuing register commands
`default_nettype none
module stsr_host (
  // Clock and answer
  input wire logic core_clk,
  input wire logic [15:0] rdData,
  // Command port
  output logic cmdValid,
  output logic cmdWrite,
  output logic [3:0] cmdSel,
  output logic [15:0] cmdWdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmdValid, cmdWrite, cmdSel, cmdWdata} = 22'h0;
  task op(input logic w, input logic [3:0] s, input logic [15:0] d, output logic [15:0] q);
    @(negedge core_clk);
    {cmdValid, cmdWrite, cmdSel, cmdWdata} = {1'h1, w, s, d};
    @(negedge core_clk);
    cmdValid = 1'h0;
    // Released data is scrambled so a stale word cannot pass
    cmdWdata = ~d;
    q = rdData;
  endtask
endmodule // stsr_host
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the status register sets
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, inArmLayer1, inArmLayer2, inMeasureLayer, clearStatus, statusPreset;
  logic cmdValid, cmdWrite, rdValid, armSummary, waitTrigSummary;
  logic [3:0] cmdSel;
  logic [15:0] cmdWdata, rdData, q;
  int n_errors, checks;
  stsr_status_regs i_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .inArmLayer1(inArmLayer1),
    .inArmLayer2(inArmLayer2),
    .inMeasureLayer(inMeasureLayer),
    .cmdValid(cmdValid),
    .cmdWrite(cmdWrite),
    .cmdSel(cmdSel),
    .cmdWdata(cmdWdata),
    .clearStatus(clearStatus),
    .statusPreset(statusPreset),
    .rdValid(rdValid),
    .rdData(rdData),
    .armSummary(armSummary),
    .waitTrigSummary(waitTrigSummary)
  );
  stsr_host i_host (
    .core_clk(core_clk),
    .rdData(rdData),
    .cmdValid(cmdValid),
    .cmdWrite(cmdWrite),
    .cmdSel(cmdSel),
    .cmdWdata(cmdWdata)
  );
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task wr(input logic [3:0] s, input logic [15:0] d);
    i_host.op(1'h1, s, d, q);
  endtask
  task rc(input logic [3:0] s, input logic [15:0] e);
    i_host.op(1'h0, s, 16'h0, q);
    chk("register read", q, e);
  endtask
  task sm(input logic [15:0] e);
    chk("summaries", {14'h0, armSummary, waitTrigSummary}, e);
  endtask
  task t_reset;
    for (int s = 1; s < 10; s++) rc(s[3:0], (s == 1 || s == 6) ? 16'hffff : 16'h0);
    wr(4'h0, 16'hffff);
    rc(4'h0, 16'h0);
    rc(4'hc, 16'h0);
    $display("t_reset done");
  endtask
  task t_arm;
    wr(4'h4, 16'hffff);
    {inArmLayer1, inArmLayer2} = 2'h3;
    wt(3);
    sm(16'h2);
    rc(4'h0, 16'h0006);
    rc(4'h3, 16'h0006);
    rc(4'h3, 16'h0);
    sm(16'h0);
    wr(4'h4, 16'h0);
    inArmLayer1 = 1'h0;
    wt(4);
    inArmLayer1 = 1'h1;
    wt(4);
    sm(16'h0);
    wr(4'h4, 16'h0002);
    wt(1);
    sm(16'h2);
    rc(4'h4, 16'h0002);
    rc(4'h3, 16'h0002);
    $display("t_arm done");
  endtask
  task t_meas;
    wr(4'h6, 16'h0);
    wr(4'h7, 16'hffff);
    wr(4'h9, 16'h0002);
    inMeasureLayer = 1'h1;
    wt(4);
    rc(4'h5, 16'h0002);
    rc(4'h8, 16'h0);
    inMeasureLayer = 1'h0;
    wt(4);
    sm(16'h1);
    clearStatus = 1'h1;
    wt(1);
    clearStatus = 1'h0;
    wt(1);
    sm(16'h0);
    rc(4'h7, 16'hffff);
    statusPreset = 1'h1;
    wt(1);
    statusPreset = 1'h0;
    rc(4'h6, 16'hffff);
    rc(4'h7, 16'h0);
    $display("t_meas done");
  endtask
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  // Whole run is about 80 cycles
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    {nrst, inArmLayer1, inArmLayer2, inMeasureLayer, clearStatus, statusPreset} = 6'h0;
    wt(2);
    nrst = 1'h1;
    t_reset;
    t_arm;
    t_meas;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
